//--- smb_mailbox.sv
// Slave port mailbox with full flags, attention output and Avalon-MM registers
// Operation
// (R1) Master command write full, slave read empties
// (R2) Master waits for empty before next byte
// (R3) Status shows full state of every mailbox
// (R4) Master command write interrupts slave when enabled
// (R5) Slave command write asserts attention output
// (R6) Slave command read raises nothing toward master
// (R7) Master dummy command write still interrupts slave
// (R8) Status read peeks without handshake side effects
// (R9) Only master starts messages; slave signals aside
// (R10) Interrupt priority writable at any time
// (R11) Master resets and boots slave via port; no reset output exists; o_boot_from_port follows i_boot_mode unless control bit 7 is set
// (R12) Command irq flags cleared by status writes
// (R13) Two-bit priority field, zero disables interrupt; unmasked irq_stat events still raise o_irq at priority zero
// (R14) Master selects registers with two select inputs
// (R15) Attention drops on master read or clear
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`include "smb_params.svh"
module smb_mailbox #(
   parameter int DW = 8
) (
   input  wire logic          i_clk,
   input  wire logic          i_reset,
   // Avalon-MM slave, slave core side
   input  wire logic [7:0]    i_avs_address,
   input  wire logic          i_avs_read,
   input  wire logic          i_avs_write,
   input  wire logic [31:0]   i_avs_writedata,
   input  wire logic [3:0]    i_avs_byteenable,
   output logic [31:0]        o_avs_readdata,
   output logic               o_avs_waitrequest,
   // Master processor pins
   input  wire logic          i_master_cs_n,
   input  wire logic          i_master_rd_n,
   input  wire logic          i_master_wr_n,
   input  wire logic [1:0]    i_port_select_inputs,
   input  wire logic [DW-1:0] i_master_data,
   output logic [DW-1:0]      o_master_data,
   output logic               o_master_data_oe,
   output logic               o_attention_to_master_n,
   input  wire logic [1:0]    i_boot_mode,
   // Slave core side
   output logic               o_boot_from_port,
   output logic [1:0]         o_irq_priority,
   output logic               o_irq
);
   smb_pkg::smb_bus_state_e           state;
   smb_pkg::smb_bus_state_e           next_state;
   smb_pkg::smb_byte_t                m_mbox [3];
   smb_pkg::smb_byte_t                s_mbox [3];
   logic [7:0]                        status;
   logic [7:0]                        control;
   logic [`SMB_EV_WIDTH-1:0]          irq_stat;
   logic [`SMB_EV_WIDTH-1:0]          irq_mask;
   logic                              attn;
   logic                              m_rd_active;
   logic                              m_rd_done;
   logic                              m_wr_done;
   logic [1:0]                        m_sel;
   logic [DW-1:0]                     m_wdata;
   logic [1:0]                        boot_mode;
   logic                              port_on;
   logic                              s_req;
   logic                              s_wr;
   logic                              s_rd;
   logic [5:0]                        s_idx;
   logic                              s_lane0;
   logic [7:0]                        s_wbyte;
   logic                              m_wr;
   logic                              m_rd;
   logic [`SMB_EV_WIDTH-1:0]          ev;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Mailbox index for a register index, or 3 when it is not a mailbox
   function automatic logic [1:0] mbox_of(input logic [5:0] idx);
      case (idx)
         `SMB_IDX_CMD:   mbox_of = 2'h0;
         `SMB_IDX_DATA1: mbox_of = 2'h1;
         `SMB_IDX_DATA2: mbox_of = 2'h2;
         default:        mbox_of = 2'h3;
      endcase
   endfunction

   // ----------------------------------------
   // Master pin synchronisation
   // ----------------------------------------
   smb_pin_sync #(
      .DW (DW)
   ) u_sync (
      .i_clk       (i_clk),
      .i_reset     (i_reset),
      .i_cs_n      (i_master_cs_n),
      .i_rd_n      (i_master_rd_n),
      .i_wr_n      (i_master_wr_n),
      .i_sel       (i_port_select_inputs),
      .i_data      (i_master_data),
      .i_boot_mode (i_boot_mode),
      .o_rd_active (m_rd_active),
      .o_rd_done   (m_rd_done),
      .o_wr_done   (m_wr_done),
      .o_sel       (m_sel),
      .o_wdata     (m_wdata),
      .o_boot_mode (boot_mode)
   );

   assign port_on = control[`SMB_CR_ENABLE];
   // Pin accesses count only while the port is enabled
   assign m_wr    = m_wr_done & port_on;                         // R14
   assign m_rd    = m_rd_done & port_on;                         // R14

   // ----------------------------------------
   // Avalon-MM handshake
   // ----------------------------------------
   // One wait state: read data is registered before waitrequest drops
   assign s_req   = i_avs_read | i_avs_write;
   assign s_idx   = i_avs_address[7:2];
   assign s_lane0 = i_avs_byteenable[0];
   assign s_wbyte = i_avs_writedata[7:0];
   assign s_wr    = (state == smb_pkg::SMB_ST_ACK) & i_avs_write & s_lane0;
   assign s_rd    = (state == smb_pkg::SMB_ST_ACK) & i_avs_read;

   always_comb begin
      next_state = state;
      case (state)
         smb_pkg::SMB_ST_IDLE: begin
            if (s_req) begin
               next_state = smb_pkg::SMB_ST_ACK;
            end
         end
         smb_pkg::SMB_ST_ACK: begin
            next_state = smb_pkg::SMB_ST_IDLE;
         end
         default: begin
            next_state = smb_pkg::SMB_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state <= smb_pkg::SMB_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign o_avs_waitrequest = s_req & (state != smb_pkg::SMB_ST_ACK);

   // Slave reads never touch attention, only the master-side flags
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_avs_readdata <= '0;
      end else if (state == smb_pkg::SMB_ST_IDLE && i_avs_read) begin
         case (s_idx)
            `SMB_IDX_CMD:      o_avs_readdata <= {24'h0, m_mbox[0]};
            `SMB_IDX_DATA1:    o_avs_readdata <= {24'h0, m_mbox[1]};
            `SMB_IDX_DATA2:    o_avs_readdata <= {24'h0, m_mbox[2]};
            `SMB_IDX_STATUS:   o_avs_readdata <= {24'h0, status};     // R3
            `SMB_IDX_CONTROL:  o_avs_readdata <= {24'h0, control[7], boot_mode,
                                                  1'b0, control[3:0]};
            `SMB_IDX_IRQ_STAT: o_avs_readdata <= {29'h0, irq_stat};
            `SMB_IDX_IRQ_MASK: o_avs_readdata <= {29'h0, irq_mask};
            default:           o_avs_readdata <= '0;
         endcase
      end
   end

   // ----------------------------------------
   // Mailbox data
   // ----------------------------------------
   // Master-written side; a dummy byte is stored like any other
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         m_mbox[0] <= '0;
         m_mbox[1] <= '0;
         m_mbox[2] <= '0;
      end else if (m_wr && m_sel != `SMB_SEL_STATUS) begin
         m_mbox[m_sel] <= m_wdata;                                // R2
      end
   end

   // Slave-written side; data regs let the slave post info unasked
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         s_mbox[0] <= '0;
         s_mbox[1] <= '0;
         s_mbox[2] <= '0;
      end else if (s_wr && mbox_of(s_idx) != 2'h3) begin
         s_mbox[mbox_of(s_idx)] <= s_wbyte;                       // R9
      end
   end

   // Pin read data; registered every cycle while the strobe is active, held after it
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_master_data    <= '0;
         o_master_data_oe <= 1'b0;
      end else begin
         o_master_data_oe <= m_rd_active & port_on;
         if (m_rd_active) begin
            if (m_sel == `SMB_SEL_STATUS) begin
               o_master_data <= status;                           // R8
            end else begin
               o_master_data <= s_mbox[m_sel];
            end
         end
      end
   end

   // ----------------------------------------
   // Full flags
   // ----------------------------------------
   // Setting events are applied after clears so that a set always wins
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         status <= '0;
      end else begin
         // Slave reads of master-written mailboxes empty them
         if (s_rd && mbox_of(s_idx) != 2'h3) begin
            status[`SMB_ST_M_FULL0 + mbox_of(s_idx)] <= 1'b0;     // R1
         end
         if (s_wr && s_idx == `SMB_IDX_STATUS) begin
            status[`SMB_ST_M_CMD_IRQ] <= 1'b0;                    // R12
         end
         // Master reads of slave-written mailboxes; status peek does nothing
         if (m_rd && m_sel != `SMB_SEL_STATUS) begin
            status[`SMB_ST_S_FULL0 + m_sel] <= 1'b0;              // R8
         end
         if (m_wr && m_sel == `SMB_SEL_STATUS) begin
            status[`SMB_ST_S_CMD_IRQ] <= 1'b0;                    // R12
         end
         if (m_wr && m_sel != `SMB_SEL_STATUS) begin
            status[`SMB_ST_M_FULL0 + m_sel] <= 1'b1;              // R1
            if (m_sel == `SMB_SEL_CMD) begin
               status[`SMB_ST_M_CMD_IRQ] <= 1'b1;                 // R7
            end
         end
         if (s_wr && mbox_of(s_idx) != 2'h3) begin
            status[`SMB_ST_S_FULL0 + mbox_of(s_idx)] <= 1'b1;     // R3
            if (s_idx == `SMB_IDX_CMD) begin
               status[`SMB_ST_S_CMD_IRQ] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Attention toward the master
   // ----------------------------------------
   // Only a slave command write raises it; slave reads never do
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         attn <= 1'b0;
      end else if (s_wr && s_idx == `SMB_IDX_CMD) begin
         attn <= 1'b1;                                            // R5
      end else if ((m_rd && m_sel == `SMB_SEL_CMD) ||
                   (m_wr && m_sel == `SMB_SEL_STATUS)) begin
         attn <= 1'b0;                                            // R15
      end
   end

   assign o_attention_to_master_n = ~attn;                        // R6

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   // Priority may change inside a handler, e.g. drop to polling after byte one
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         control <= `SMB_CR_RESET;
      end else if (s_wr && s_idx == `SMB_IDX_CONTROL) begin
         control <= {s_wbyte[7], 3'h0, s_wbyte[3:0]};             // R10
      end
   end

   // Boot via the port while the boot pins ask for it and are obeyed
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_boot_from_port <= 1'b0;
      end else begin
         o_boot_from_port <= ~control[`SMB_CR_IGN_BOOT] &
                             (boot_mode == `SMB_BOOT_PORT);       // R11
      end
   end

   assign o_irq_priority = control[`SMB_CR_PRIO_LSB +: 2];        // R13

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign ev[`SMB_EV_CMD_IN]    = m_wr & (m_sel == `SMB_SEL_CMD);
   assign ev[`SMB_EV_DATA_IN]   = m_wr & (m_sel == `SMB_SEL_DATA1 ||
                                          m_sel == `SMB_SEL_DATA2);
   assign ev[`SMB_EV_CMD_TAKEN] = m_rd & (m_sel == `SMB_SEL_CMD);

   // Write one to clear; a simultaneous event keeps its bit set
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         irq_stat <= '0;
      end else if (s_wr && s_idx == `SMB_IDX_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~s_wbyte[`SMB_EV_WIDTH-1:0]) | ev;
      end else begin
         irq_stat <= irq_stat | ev;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         irq_mask <= '0;
      end else if (s_wr && s_idx == `SMB_IDX_IRQ_MASK) begin
         irq_mask <= s_wbyte[`SMB_EV_WIDTH-1:0];
      end
   end

   // Command flag drives the port interrupt unless priority is zero
   assign o_irq = (status[`SMB_ST_M_CMD_IRQ] & (o_irq_priority != 2'h0)) |  // R4
                  (|(irq_stat & irq_mask));
endmodule

//--- smb_params.svh
// Offsets, field positions and reset values of the slave port mailbox
`ifndef SMB_PARAMS_SVH
`define SMB_PARAMS_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define SMB_IDX_CMD      6'h20
`define SMB_IDX_DATA1    6'h21
`define SMB_IDX_DATA2    6'h22
`define SMB_IDX_STATUS   6'h23
`define SMB_IDX_CONTROL  6'h24
`define SMB_IDX_IRQ_STAT 6'h25
`define SMB_IDX_IRQ_MASK 6'h26

// ----------------------------------------
// Pin-side select codes
// ----------------------------------------
`define SMB_SEL_CMD      2'h0
`define SMB_SEL_DATA1    2'h1
`define SMB_SEL_DATA2    2'h2
`define SMB_SEL_STATUS   2'h3

// ----------------------------------------
// Status flag positions: full flags and command irq flags
// ----------------------------------------
`define SMB_ST_M_CMD_IRQ 7
`define SMB_ST_M_FULL0   4
`define SMB_ST_S_CMD_IRQ 3
`define SMB_ST_S_FULL0   0

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SMB_CR_IGN_BOOT  7
`define SMB_CR_BOOT_LSB  5
`define SMB_CR_ENABLE    3
`define SMB_CR_PRIO_LSB  0
`define SMB_CR_RESET     8'h08
`define SMB_BOOT_PORT    2'h1

// ----------------------------------------
// Interrupt event bits
// ----------------------------------------
`define SMB_EV_CMD_IN    0
`define SMB_EV_DATA_IN   1
`define SMB_EV_CMD_TAKEN 2
`define SMB_EV_WIDTH     3

`endif

//--- smb_pkg.sv
// Types shared by the slave port mailbox
package smb_pkg;
   typedef enum logic [1:0] {
      SMB_ST_IDLE = 2'b01,
      SMB_ST_ACK  = 2'b10
   } smb_bus_state_e;
   typedef logic [7:0] smb_byte_t;
endpackage

//--- smb_pin_sync.sv
// Master-side pin synchroniser and access strobe extraction
`timescale 1ns/1ns
module smb_pin_sync #(
   parameter int DW = 8
) (
   input  wire logic          i_clk,
   input  wire logic          i_reset,
   input  wire logic          i_cs_n,
   input  wire logic          i_rd_n,
   input  wire logic          i_wr_n,
   input  wire logic [1:0]    i_sel,
   input  wire logic [DW-1:0] i_data,
   input  wire logic [1:0]    i_boot_mode,
   output logic               o_rd_active,
   output logic               o_rd_done,
   output logic               o_wr_done,
   output logic [1:0]         o_sel,
   output logic [DW-1:0]      o_wdata,
   output logic [1:0]         o_boot_mode
);
   localparam int W = 3 + 2 + DW + 2;
   logic [W-1:0] meta;
   logic [W-1:0] sync;
   logic         rd_q;
   logic         wr_q;
   logic         rd_now;
   logic         wr_now;

   // ----------------------------------------
   // Two-stage synchroniser
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         // Strobes rest high, so no false access follows reset
         meta <= {3'b111, {(W-3){1'b0}}};
         sync <= {3'b111, {(W-3){1'b0}}};
      end else begin
         meta <= {i_cs_n, i_rd_n, i_wr_n, i_sel, i_data, i_boot_mode};
         sync <= meta;
      end
   end

   assign rd_now = ~sync[W-1] & ~sync[W-2];
   assign wr_now = ~sync[W-1] & ~sync[W-3];

   // Access ends on strobe release: data is settled and the master has sampled
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         o_sel   <= '0;
         o_wdata <= '0;
      end else begin
         rd_q <= rd_now;
         wr_q <= wr_now;
         if (rd_now | wr_now) begin
            o_sel   <= sync[W-4:W-5];
            o_wdata <= sync[W-6:2];
         end
      end
   end

   assign o_rd_active = rd_now;
   assign o_rd_done   = rd_q & ~rd_now;
   assign o_wr_done   = wr_q & ~wr_now;
   assign o_boot_mode = sync[1:0];
endmodule

//--- smb_mailbox_chk.sv
// Port assertions for the slave port mailbox
`timescale 1ns/1ns
module smb_mailbox_chk (
   input wire logic        i_clk,
   input wire logic        i_reset,
   input wire logic [7:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic        o_avs_waitrequest,
   input wire logic        i_master_cs_n,
   input wire logic        i_master_rd_n,
   input wire logic        i_master_wr_n,
   input wire logic [1:0]  i_port_select_inputs,
   input wire logic        o_master_data_oe,
   input wire logic        o_attention_to_master_n,
   input wire logic [1:0]  i_boot_mode,
   input wire logic        o_boot_from_port,
   input wire logic [1:0]  o_irq_priority,
   input wire logic        o_irq
);
   // ----------------------------------------
   // Completed Avalon accesses and master chip select
   // ----------------------------------------
   wire logic wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   wire logic rd_ok = i_avs_read && !o_avs_waitrequest;
   wire logic pin_on = !i_master_cs_n;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   a_wait_one: assert property (
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("waitrequest held past one cycle");
   a_wait_idle: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
      else $error("waitrequest high without request");
   a_attn_set: assert property (
      wr_ok && i_avs_address == 8'h80 |=> !o_attention_to_master_n)
      else $error("attention not raised by slave command write");
   a_attn_quiet: assert property (
      rd_ok && i_avs_address == 8'h80 |=> $stable(o_attention_to_master_n))
      else $error("slave command read moved attention");
   a_prio_load: assert property (
      wr_ok && i_avs_address == 8'h90 |=> o_irq_priority == $past(i_avs_writedata[1:0]))
      else $error("priority field not loaded");
   a_irq_cmd: assert property (
      $rose(i_master_wr_n) && pin_on && i_port_select_inputs == 2'h0
      && o_irq_priority != 2'h0 |-> ##[1:6] o_irq)
      else $error("master command write raised no interrupt");
   a_attn_drop: assert property (
      $rose(i_master_rd_n) && pin_on && i_port_select_inputs == 2'h0
      |-> ##[1:6] o_attention_to_master_n)
      else $error("attention kept after master command read");
   a_peek_keep: assert property (
      $rose(i_master_rd_n) && pin_on && i_port_select_inputs == 2'h3
      && !o_attention_to_master_n |-> !o_attention_to_master_n [*6])
      else $error("status peek disturbed attention");
   a_oe_off: assert property (i_master_rd_n [*5] |-> !o_master_data_oe)
      else $error("data bus driven without read strobe");
   a_boot_off: assert property ((i_boot_mode != 2'h1) [*5] |-> !o_boot_from_port)
      else $error("port boot without boot pins");

   c_slave_cmd: cover property (wr_ok && i_avs_address == 8'h80);
   c_master_cmd: cover property ($rose(i_master_wr_n) && pin_on && i_port_select_inputs == 2'h0);
   c_prio_top: cover property (wr_ok && i_avs_address == 8'h90 && i_avs_writedata[1:0] == 2'h3);
endmodule

//--- smb_master_model.sv
// Behavioural master processor on the slave port pins
`timescale 1ns/1ns
module smb_master_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_dq,
   input  wire logic       i_dq_oe,
   output logic            o_cs_n,
   output logic            o_rd_n,
   output logic            o_wr_n,
   output logic [1:0]      o_sel,
   output logic [7:0]      o_dq
);
   logic       drv = 1'h0;
   logic [7:0] wdat = 8'h00;
   logic [7:0] last = 8'h00;
   // Undriven bus toggles each cycle so a stale byte never reads as valid
   assign o_dq = drv ? wdat : (i_dq_oe ? i_dq : ~last);
   always @(posedge i_clk) last <= o_dq;
   initial begin
      o_cs_n = 1'h1;
      o_rd_n = 1'h1;
      o_wr_n = 1'h1;
      o_sel = 2'h0;
   end
   // Strobe held five cycles, above the synchroniser's two
   task automatic access(input logic [1:0] s, input logic w, input logic [7:0] d,
                         output logic [7:0] q);
      o_sel <= s;
      wdat <= d;
      drv <= w;
      o_cs_n <= 1'h0;
      @(posedge i_clk);
      if (w) o_wr_n <= 1'h0;
      else o_rd_n <= 1'h0;
      repeat (5) @(posedge i_clk);
      q = o_dq;
      o_wr_n <= 1'h1;
      o_rd_n <= 1'h1;
      @(posedge i_clk);
      o_cs_n <= 1'h1;
      // Data kept until the late, synchronised release is taken
      repeat (5) @(posedge i_clk);
      drv <= 1'h0;
      @(posedge i_clk);
   endtask
   task automatic send_cmd(input logic [7:0] d);
      logic [7:0] st;
      int         n = 0;
      do begin access(2'h3, 1'h0, 8'h00, st); n++; end while (st[4] !== 1'h0 && n < 20);
      if (st[4] !== 1'h0) tb_top.chk1("drained", 1'h0, st[4]);
      access(2'h0, 1'h1, d, st);
   endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the slave port mailbox
`timescale 1ns/1ns
module tb_top;
   logic        i_clk = 1'h0;
   logic        i_reset = 1'h1;
   logic [7:0]  av_addr = 8'h00;
   logic        av_rd = 1'h0;
   logic        av_wr = 1'h0;
   logic [31:0] av_wdata = 32'h0;
   logic [3:0]  av_be = 4'hf;
   logic [31:0] av_rdata;
   logic        av_wait;
   logic        cs_n, rd_n, wr_n, dut_oe, attn_n, boot, irq;
   logic [1:0]  sel, prio;
   logic [1:0]  boot_pins = 2'h0;
   logic [7:0]  mdq, dut_dq, rb;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          cycles = 0;

   always #20 i_clk = ~i_clk;
   smb_mailbox u_dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_avs_address(av_addr), .i_avs_read(av_rd),
      .i_avs_write(av_wr), .i_avs_writedata(av_wdata), .i_avs_byteenable(av_be),
      .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .i_master_cs_n(cs_n),
      .i_master_rd_n(rd_n), .i_master_wr_n(wr_n), .i_port_select_inputs(sel),
      .i_master_data(mdq), .o_master_data(dut_dq), .o_master_data_oe(dut_oe),
      .o_attention_to_master_n(attn_n), .i_boot_mode(boot_pins),
      .o_boot_from_port(boot), .o_irq_priority(prio), .o_irq(irq));
   smb_master_model u_mst (
      .i_clk(i_clk), .i_dq(dut_dq), .i_dq_oe(dut_oe), .o_cs_n(cs_n), .o_rd_n(rd_n),
      .o_wr_n(wr_n), .o_sel(sel), .o_dq(mdq));

   // ----------------------------------------
   // Compare and bus tasks
   // ----------------------------------------
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk1(input string what, input logic exp, input logic got);
      chk8(what, {7'h0, exp}, {7'h0, got});
   endtask
   task automatic av(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n = 0;
      av_addr <= a;
      av_wr <= w;
      av_rd <= !w;
      av_wdata <= {24'h0, d};
      do begin @(posedge i_clk); n++; end while (av_wait !== 1'h0 && n < 20);
      rb = av_rdata[7:0];
      if (n >= 20) chk1("waitrequest", 1'h0, av_wait);
      av_wr <= 1'h0;
      av_rd <= 1'h0;
      @(posedge i_clk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk1("attention idle", 1'h1, attn_n);
      chk1("irq idle", 1'h0, irq);
      av(8'h90, 1'h0, 8'h00);
      chk8("control reset", 8'h08, rb);
      av(8'h8c, 1'h0, 8'h00);
      chk8("status reset", 8'h00, rb);
      av(8'h9c, 1'h0, 8'h00);
      chk8("unmapped", 8'h00, rb);
      av_be <= 4'h0;
      av(8'h90, 1'h1, 8'h0b);
      av_be <= 4'hf;
      av(8'h90, 1'h0, 8'h00);
      chk8("control kept", 8'h08, rb);
      $display("t_reset done");
   endtask
   task automatic t_prio;
      for (int p = 0; p < 4; p++) begin
         av(8'h90, 1'h1, 8'(8'h08 + p));
         chk8("priority", 8'(p), {6'h0, prio});
      end
      $display("t_prio done");
   endtask
   task automatic t_msg;
      av(8'h90, 1'h1, 8'h09);
      u_mst.send_cmd(8'h5a);
      chk1("irq on command", 1'h1, irq);
      av(8'h8c, 1'h0, 8'h00);
      chk8("status full", 8'h90, rb);
      u_mst.access(2'h3, 1'h0, 8'h00, rb);
      chk8("pin status", 8'h90, rb);
      av(8'h80, 1'h0, 8'h00);
      chk8("command byte", 8'h5a, rb);
      chk1("no attention", 1'h1, attn_n);
      av(8'h8c, 1'h0, 8'h00);
      chk8("status empty", 8'h80, rb);
      av(8'h8c, 1'h1, 8'h00);
      chk1("irq cleared", 1'h0, irq);
      u_mst.send_cmd(8'h00);
      chk1("dummy irq", 1'h1, irq);
      av(8'h80, 1'h0, 8'h00);
      av(8'h8c, 1'h1, 8'h00);
      $display("t_msg done");
   endtask
   task automatic t_irq;
      av(8'h90, 1'h1, 8'h08);
      av(8'h94, 1'h1, 8'h07);
      u_mst.access(2'h0, 1'h1, 8'h33, rb);
      chk1("irq disabled", 1'h0, irq);
      av(8'h94, 1'h0, 8'h00);
      chk8("event status", 8'h01, rb);
      av(8'h98, 1'h1, 8'h01);
      chk1("irq unmasked", 1'h1, irq);
      av(8'h94, 1'h1, 8'h01);
      chk1("irq w1c", 1'h0, irq);
      av(8'h80, 1'h0, 8'h00);
      av(8'h8c, 1'h1, 8'h00);
      av(8'h90, 1'h1, 8'h00);
      u_mst.access(2'h0, 1'h1, 8'h44, rb);
      av(8'h8c, 1'h0, 8'h00);
      chk8("port off", 8'h00, rb);
      av(8'h90, 1'h1, 8'h08);
      $display("t_irq done");
   endtask
   task automatic t_attn;
      av(8'h80, 1'h1, 8'hc3);
      chk1("attention set", 1'h0, attn_n);
      u_mst.access(2'h3, 1'h0, 8'h00, rb);
      chk8("peek", 8'h09, rb);
      chk1("attention after peek", 1'h0, attn_n);
      u_mst.access(2'h0, 1'h0, 8'h00, rb);
      chk8("pin command", 8'hc3, rb);
      chk1("attention dropped", 1'h1, attn_n);
      av(8'h8c, 1'h0, 8'h00);
      chk8("status flag kept", 8'h08, rb);
      av(8'h80, 1'h1, 8'h3c);
      u_mst.access(2'h3, 1'h1, 8'h00, rb);
      chk1("attention cleared", 1'h1, attn_n);
      av(8'h8c, 1'h0, 8'h00);
      chk8("status after clear", 8'h01, rb);
      u_mst.access(2'h0, 1'h0, 8'h00, rb);
      $display("t_attn done");
   endtask
   task automatic t_data;
      for (int i = 1; i < 3; i++) begin
         u_mst.access(2'(i), 1'h1, 8'(8'h10 + i), rb);
         av(8'h8c, 1'h0, 8'h00);
         chk8("status in", 8'(8'h10 << i), rb);
         av(8'(8'h80 + 4 * i), 1'h0, 8'h00);
         chk8("data in", 8'(8'h10 + i), rb);
         av(8'(8'h80 + 4 * i), 1'h1, 8'(8'ha0 + i));
         av(8'h8c, 1'h0, 8'h00);
         chk8("status out", 8'(8'h01 << i), rb);
         u_mst.access(2'(i), 1'h0, 8'h00, rb);
         chk8("data out", 8'(8'ha0 + i), rb);
      end
      chk1("no attention on data", 1'h1, attn_n);
      av(8'h8c, 1'h0, 8'h00);
      chk8("status drained", 8'h00, rb);
      av(8'h94, 1'h0, 8'h00);
      chk8("events", 8'h06, rb);
      $display("t_data done");
   endtask
   task automatic t_boot;
      boot_pins <= 2'h1;
      repeat (6) @(posedge i_clk);
      chk1("port boot", 1'h1, boot);
      av(8'h90, 1'h0, 8'h00);
      chk8("control pins", 8'h28, rb);
      av(8'h90, 1'h1, 8'h88);
      @(posedge i_clk);
      chk1("boot pins ignored", 1'h0, boot);
      boot_pins <= 2'h0;
      $display("t_boot done");
   endtask

   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge i_clk);
      i_reset <= 1'h0;
      repeat (3) @(posedge i_clk);
      t_reset;
      t_prio;
      t_msg;
      t_irq;
      t_attn;
      t_data;
      t_boot;
      wrap_up;
   end
   // Whole run needs about 350 cycles
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         error_cnt++;
         $display("BAD run length expected under 8000 seen %0d", cycles);
         wrap_up;
      end
   end
endmodule

bind smb_mailbox smb_mailbox_chk u_chk (
   .i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
   .i_avs_byteenable, .o_avs_waitrequest, .i_master_cs_n, .i_master_rd_n, .i_master_wr_n,
   .i_port_select_inputs, .o_master_data_oe, .o_attention_to_master_n, .i_boot_mode,
   .o_boot_from_port, .o_irq_priority, .o_irq);
